// [spi_cmd_host_model.sv]
// host-side serial master model driving the command port
`timescale 1ns/100ps
module spi_cmd_host_model (
  // serial link pins
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out,
  input wire logic sdo_in
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // ----------------------------------------
  // word transfer
  // ----------------------------------------
  // n bits of w go out msb first on a 200 ns link clock; reply gathered one bit behind
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    cs_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi_out = w[15 - i];
      #100;
      sclk_out = 1'b1;
      #90;
      if (i > 0) begin
        rd = {rd[14:0], sdo_in};
      end
      #10;
      sclk_out = 1'b0;
    end
    #190;
    rd = {rd[14:0], sdo_in};
    cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #250;
  endtask
endmodule

// [spi_cmd_pkg.sv]
// types shared by the serial command port
package spi_cmd_pkg;

  typedef enum logic [4:0] {
    REG_GENERAL_CONFIG,
    REG_FREQ_CTRL_CONFIG,
    REG_TRANSMIT_CONFIG,
    REG_TRANSMIT_BYTE,
    REG_CENTER_FREQUENCY,
    REG_RECEIVE_CONTROL,
    REG_BASEBAND_FILTER_CONFIG,
    REG_RECEIVE_BYTE_READ,
    REG_BUFFER_RESET_CONFIG,
    REG_SYNC_PATTERN,
    REG_DATA_RATE,
    REG_POWER_MANAGEMENT,
    REG_WAKEUP_PERIOD,
    REG_DUTY_CYCLE,
    REG_BATTERY_AND_CLOCK_OUT,
    REG_PLL_CONFIG,
    REG_NONE
  } reg_sel_e;

  typedef struct packed {
    logic [15:0] general_config;
    logic [15:0] freq_ctrl_config;
    logic [15:0] transmit_config;
    logic [15:0] transmit_byte;
    logic [15:0] center_frequency;
    logic [15:0] receive_control;
    logic [15:0] baseband_filter_config;
    logic [15:0] receive_byte_read;
    logic [15:0] buffer_reset_config;
    logic [15:0] sync_pattern;
    logic [15:0] data_rate;
    logic [15:0] power_management;
    logic [15:0] wakeup_period;
    logic [15:0] duty_cycle;
    logic [15:0] battery_and_clock_out;
    logic [15:0] pll_config;
  } cfg_regs_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT,
    ST_DONE
  } link_state_e;

endpackage

// [spi_cmd_regs.svh]
// register defaults, command prefixes and field positions of the serial command port
`ifndef SPI_CMD_REGS_SVH
`define SPI_CMD_REGS_SVH

`define WORD_BITS 16
`define SCLK_MAX_HZ 20000000

// power-on defaults
`define RST_STATUS_WORD 16'h0000
`define RST_GENERAL_CONFIG 16'h8008
`define RST_FREQ_CTRL_CONFIG 16'hc4f7
`define RST_TRANSMIT_CONFIG 16'h9800
`define RST_TRANSMIT_BYTE 16'hb8aa
`define RST_CENTER_FREQUENCY 16'ha680
`define RST_RECEIVE_CONTROL 16'h9080
`define RST_BASEBAND_FILTER_CONFIG 16'hc22c
`define RST_RECEIVE_BYTE_READ 16'hb000
`define RST_BUFFER_RESET_CONFIG 16'hca80
`define RST_SYNC_PATTERN 16'hced4
`define RST_DATA_RATE 16'hc623
`define RST_POWER_MANAGEMENT 16'h8208
`define RST_WAKEUP_PERIOD 16'he196
`define RST_DUTY_CYCLE 16'hc80e
`define RST_BATTERY_AND_CLOCK_OUT 16'hc000
`define RST_PLL_CONFIG 16'hcc77

// command prefixes
`define CMD_GENERAL_CONFIG 8'h80
`define CMD_FREQ_CTRL_CONFIG 8'hc4
`define CMD_TRANSMIT_CONFIG 7'h4c
`define CMD_TRANSMIT_BYTE 8'hb8
`define CMD_CENTER_FREQUENCY 4'ha
`define CMD_RECEIVE_CONTROL 5'h12
`define CMD_BASEBAND_FILTER_CONFIG 8'hc2
`define CMD_RECEIVE_BYTE_READ 8'hb0
`define CMD_BUFFER_RESET_CONFIG 8'hca
`define CMD_SYNC_PATTERN 8'hce
`define CMD_DATA_RATE 8'hc6
`define CMD_POWER_MANAGEMENT 8'h82
`define CMD_WAKEUP_PERIOD 3'h7
`define CMD_DUTY_CYCLE 8'hc8
`define CMD_BATTERY_AND_CLOCK_OUT 8'hc0
`define CMD_PLL_CONFIG 8'hcc

// status word bit positions of sticky flags
`define STS_TX_RX_FIFO 15
`define STS_POWER_ON 14
`define STS_OVERRUN 13
`define STS_WAKEUP 12
`define STS_EXT_EDGE 11
`define STS_STICKY_MASK 16'hf800

// pll config bit that always holds one
`define PLL_FIXED_ONE_BIT 4

`endif

// [spi_command_register_decoder.sv]
// serial command port: word shifter, prefix decoder, configuration registers and status read
`timescale 1ns/100ps
`include "spi_cmd_regs.svh"

// Overview of operation
// - mode 0: clock idles low, input sampled on rising edge while selected
// - serial output changes on each falling clock edge
// - words travel most significant bit first, bit 15 leads
// - serial output held low with its output enable off while chip select is high
// - reset loads every register with its default value
// - programmed values stay unchanged in sleep
// - seventeen commands, prefix selects register, remaining bits are parameters
// - upper byte 80 writes general configuration, default 8008
// - upper byte c4 writes frequency control configuration, default c4f7
// - bits 15:9 1001100 write transmit configuration, default 9800
// - b8 loads transmit byte, b0 reads receive byte, ce sets sync byte
// - bits 15:12 1010 write centre frequency, default a680
// - bits 15:11 10010 write receive control, default 9080
// - upper byte c2 writes baseband filter configuration, default c22c
// - upper byte ca writes buffer and reset configuration, default ca80
// - upper byte c6 writes data rate, default c623
// - upper byte 82 writes power management, default 8208
// - prefix 111 writes wake-up period; c8 writes duty cycle
// - upper byte c0 writes battery threshold and clock output, default c000
// - upper byte cc writes pll configuration, bit 4 fixed one
// - deselect clears the shift state so each selection starts fresh
// - first bit zero is a status read returning the status word
// - sticky status flags reported by a status read clear once that read completes
module spi_command_register_decoder (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // serial link pins
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // device state: status word sources, receive byte for read-out, sleep flag
  input wire logic [15:0] status_src_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic sleep_in,
  // register contents and receive read pulse to the radio
  output spi_cmd_pkg::cfg_regs_s cfg_out,
  output logic rx_byte_read_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic spi_cmd_pkg::reg_sel_e decode_cmd(input logic [15:0] w);
    spi_cmd_pkg::reg_sel_e s;
    s = spi_cmd_pkg::REG_NONE;
    if (w[15:13] == `CMD_WAKEUP_PERIOD)
      s = spi_cmd_pkg::REG_WAKEUP_PERIOD;
    else if (w[15:12] == `CMD_CENTER_FREQUENCY)
      s = spi_cmd_pkg::REG_CENTER_FREQUENCY;
    else if (w[15:11] == `CMD_RECEIVE_CONTROL)
      s = spi_cmd_pkg::REG_RECEIVE_CONTROL;
    else if (w[15:9] == `CMD_TRANSMIT_CONFIG)
      s = spi_cmd_pkg::REG_TRANSMIT_CONFIG;
    else begin
      case (w[15:8])
        `CMD_GENERAL_CONFIG: s = spi_cmd_pkg::REG_GENERAL_CONFIG;
        `CMD_FREQ_CTRL_CONFIG: s = spi_cmd_pkg::REG_FREQ_CTRL_CONFIG;
        `CMD_TRANSMIT_BYTE: s = spi_cmd_pkg::REG_TRANSMIT_BYTE;
        `CMD_RECEIVE_BYTE_READ: s = spi_cmd_pkg::REG_RECEIVE_BYTE_READ;
        `CMD_SYNC_PATTERN: s = spi_cmd_pkg::REG_SYNC_PATTERN;
        `CMD_BASEBAND_FILTER_CONFIG: s = spi_cmd_pkg::REG_BASEBAND_FILTER_CONFIG;
        `CMD_BUFFER_RESET_CONFIG: s = spi_cmd_pkg::REG_BUFFER_RESET_CONFIG;
        `CMD_DATA_RATE: s = spi_cmd_pkg::REG_DATA_RATE;
        `CMD_POWER_MANAGEMENT: s = spi_cmd_pkg::REG_POWER_MANAGEMENT;
        `CMD_DUTY_CYCLE: s = spi_cmd_pkg::REG_DUTY_CYCLE;
        `CMD_BATTERY_AND_CLOCK_OUT: s = spi_cmd_pkg::REG_BATTERY_AND_CLOCK_OUT;
        `CMD_PLL_CONFIG: s = spi_cmd_pkg::REG_PLL_CONFIG;
        default: s = spi_cmd_pkg::REG_NONE;
      endcase
    end
    return s;
  endfunction

  // live status with the latched event flags merged into the top bits
  function automatic logic [15:0] status_compose(input logic [15:0] sticky, input logic [15:0] live);
    logic [15:0] v;
    v = (sticky & `STS_STICKY_MASK) | (live & ~`STS_STICKY_MASK);
    return v;
  endfunction

  // first byte of a receive byte read command
  function automatic logic is_rx_read(input logic [7:0] b);
    logic hit;
    hit = (b == `CMD_RECEIVE_BYTE_READ);
    return hit;
  endfunction

  // unused bits hold a fixed value whatever the host wrote
  function automatic logic [15:0] fixed_bits(input spi_cmd_pkg::reg_sel_e s, input logic [15:0] w);
    logic [15:0] v;
    v = w;
    case (s)
      spi_cmd_pkg::REG_TRANSMIT_CONFIG: begin
        v[3] = 1'b0;
      end
      spi_cmd_pkg::REG_RECEIVE_BYTE_READ: begin
        v[7:0] = 8'h00;
      end
      spi_cmd_pkg::REG_BATTERY_AND_CLOCK_OUT: begin
        v[4] = 1'b0;
      end
      spi_cmd_pkg::REG_PLL_CONFIG: begin
        v[`PLL_FIXED_ONE_BIT] = 1'b1;
      end
      default: begin
        v = w;
      end
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // every link edge shows up about three system clocks late, so the
  // link clock must stay well below a quarter of the system clock;
  // all three pins pass the same depth and stay in step with each other
  logic [1:0] sclk_sync_r;
  logic [1:0] cs_sync_r;
  logic [1:0] sdi_sync_r;
  logic sclk_d_r;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_sync_r <= 2'h0;
      cs_sync_r <= 2'h3;
      sdi_sync_r <= 2'h0;
      sclk_d_r <= 1'b0;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], sclk_in};
      cs_sync_r <= {cs_sync_r[0], cs_n_in};
      sdi_sync_r <= {sdi_sync_r[0], sdi_in};
      sclk_d_r <= sclk_sync_r[1];
    end
  end

  logic sclk_s;
  logic cs_s;
  logic sdi_s;
  logic sclk_rise;
  logic sclk_fall;
  assign sclk_s = sclk_sync_r[1];
  assign cs_s = cs_sync_r[1];
  assign sdi_s = sdi_sync_r[1];
  assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_s;
  assign sclk_fall = ~sclk_s & sclk_d_r & ~cs_s;

  // ----------------------------------------------------------------
  // word shifter
  // ----------------------------------------------------------------
  spi_cmd_pkg::link_state_e state_r;
  logic [15:0] shift_r;
  logic [4:0] bit_cnt_r;
  logic word_done;
  logic [15:0] word_full;

  // a word counts only when all sixteen rises land inside one selection
  assign word_full = {shift_r[14:0], sdi_s};
  assign word_done = sclk_rise && (bit_cnt_r == 5'(`WORD_BITS - 1));

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= spi_cmd_pkg::ST_IDLE;
      shift_r <= 16'h0000;
      bit_cnt_r <= 5'h00;
    end else if (cs_s) begin
      state_r <= spi_cmd_pkg::ST_IDLE;
      shift_r <= 16'h0000;
      bit_cnt_r <= 5'h00;
    end else begin
      case (state_r)
        spi_cmd_pkg::ST_IDLE,
        spi_cmd_pkg::ST_SHIFT: begin
          if (sclk_rise) begin
            shift_r <= word_full;
            bit_cnt_r <= bit_cnt_r + 5'h01;
            state_r <= word_done ? spi_cmd_pkg::ST_DONE : spi_cmd_pkg::ST_SHIFT;
          end
        end
        spi_cmd_pkg::ST_DONE: begin
          // extra clocks past a full word are ignored until deselect
          state_r <= spi_cmd_pkg::ST_DONE;
        end
        default: state_r <= spi_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  logic status_read;
  logic first_bit_seen;
  assign first_bit_seen = sclk_rise && (bit_cnt_r == 5'h00) && (state_r == spi_cmd_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  spi_cmd_pkg::reg_sel_e sel;
  logic [15:0] wr_val;
  assign sel = decode_cmd(word_full);
  assign wr_val = fixed_bits(sel, word_full);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cfg_out.general_config <= `RST_GENERAL_CONFIG;
      cfg_out.freq_ctrl_config <= `RST_FREQ_CTRL_CONFIG;
      cfg_out.transmit_config <= `RST_TRANSMIT_CONFIG;
      cfg_out.transmit_byte <= `RST_TRANSMIT_BYTE;
      cfg_out.center_frequency <= `RST_CENTER_FREQUENCY;
      cfg_out.receive_control <= `RST_RECEIVE_CONTROL;
      cfg_out.baseband_filter_config <= `RST_BASEBAND_FILTER_CONFIG;
      cfg_out.receive_byte_read <= `RST_RECEIVE_BYTE_READ;
      cfg_out.buffer_reset_config <= `RST_BUFFER_RESET_CONFIG;
      cfg_out.sync_pattern <= `RST_SYNC_PATTERN;
      cfg_out.data_rate <= `RST_DATA_RATE;
      cfg_out.power_management <= `RST_POWER_MANAGEMENT;
      cfg_out.wakeup_period <= `RST_WAKEUP_PERIOD;
      cfg_out.duty_cycle <= `RST_DUTY_CYCLE;
      cfg_out.battery_and_clock_out <= `RST_BATTERY_AND_CLOCK_OUT;
      cfg_out.pll_config <= `RST_PLL_CONFIG;
    end else if (word_done && word_full[15] && !cs_s) begin
      // sleep_in gates nothing here: values persist through sleep
      // a word cut short never reaches this point
      case (sel)
        spi_cmd_pkg::REG_GENERAL_CONFIG: cfg_out.general_config <= word_full;
        spi_cmd_pkg::REG_FREQ_CTRL_CONFIG: cfg_out.freq_ctrl_config <= word_full;
        spi_cmd_pkg::REG_TRANSMIT_CONFIG: cfg_out.transmit_config <= wr_val;
        spi_cmd_pkg::REG_TRANSMIT_BYTE: cfg_out.transmit_byte <= word_full;
        spi_cmd_pkg::REG_CENTER_FREQUENCY: cfg_out.center_frequency <= word_full;
        spi_cmd_pkg::REG_RECEIVE_CONTROL: cfg_out.receive_control <= word_full;
        spi_cmd_pkg::REG_BASEBAND_FILTER_CONFIG: cfg_out.baseband_filter_config <= word_full;
        spi_cmd_pkg::REG_RECEIVE_BYTE_READ: cfg_out.receive_byte_read <= wr_val;
        spi_cmd_pkg::REG_BUFFER_RESET_CONFIG: cfg_out.buffer_reset_config <= word_full;
        spi_cmd_pkg::REG_SYNC_PATTERN: cfg_out.sync_pattern <= word_full;
        spi_cmd_pkg::REG_DATA_RATE: cfg_out.data_rate <= word_full;
        spi_cmd_pkg::REG_POWER_MANAGEMENT: cfg_out.power_management <= word_full;
        spi_cmd_pkg::REG_WAKEUP_PERIOD: cfg_out.wakeup_period <= word_full;
        spi_cmd_pkg::REG_DUTY_CYCLE: cfg_out.duty_cycle <= word_full;
        spi_cmd_pkg::REG_BATTERY_AND_CLOCK_OUT: cfg_out.battery_and_clock_out <= wr_val;
        spi_cmd_pkg::REG_PLL_CONFIG: cfg_out.pll_config <= wr_val;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status flags and read-out
  // ----------------------------------------------------------------
  logic [15:0] sticky_r;
  logic [15:0] sticky_nxt;
  logic [15:0] snap_r;
  logic [15:0] tx_shift_r;
  logic stat_mode_r;
  logic stat_clear;

  // the snapshot taken at the first rise is what the host sees, so only
  // the flags it actually reported are cleared at the end of the word
  assign status_read = first_bit_seen && !sdi_s;
  assign stat_clear = word_done && stat_mode_r;

  always_comb begin
    sticky_nxt = sticky_r;
    if (stat_clear)
      sticky_nxt = sticky_r & ~snap_r;
    // a new event wins over the clear
    sticky_nxt = sticky_nxt | (status_src_in & `STS_STICKY_MASK);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sticky_r <= 16'h0000;
      sticky_r[`STS_POWER_ON] <= 1'b1;
    end else begin
      sticky_r <= sticky_nxt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_mode_r <= 1'b0;
      snap_r <= `RST_STATUS_WORD;
    end else if (cs_s) begin
      stat_mode_r <= 1'b0;
    end else if (status_read) begin
      // read mode lasts until deselect so bit 0 still leaves on the sixteenth fall
      stat_mode_r <= 1'b1;
      snap_r <= status_compose(sticky_r, status_src_in);
    end
  end

  // the read pulse tells the receive buffer that its byte has gone out
  logic rx_read_mode_r;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_read_mode_r <= 1'b0;
      rx_byte_read_out <= 1'b0;
    end else begin
      rx_byte_read_out <= 1'b0;
      if (cs_s)
        rx_read_mode_r <= 1'b0;
      else if (sclk_rise && bit_cnt_r == 5'h07)
        // the first byte decides whether the low half carries the receive byte
        rx_read_mode_r <= is_rx_read(word_full[7:0]);
      if (word_done && rx_read_mode_r)
        rx_byte_read_out <= 1'b1;
    end
  end

  // serial output: status bits follow the leading zero, rx byte in the low half
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_shift_r <= 16'h0000;
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
    end else if (cs_s) begin
      tx_shift_r <= 16'h0000;
      sdo_out <= 1'b0;
      sdo_oe_out <= 1'b0;
    end else begin
      sdo_oe_out <= 1'b1;
      // falls past the last reported bit shift out zeros until deselect
      if (status_read)
        tx_shift_r <= status_compose(sticky_r, status_src_in);
      else if (sclk_rise && bit_cnt_r == 5'h07 && is_rx_read(word_full[7:0]))
        tx_shift_r <= {rx_byte_in, 8'h00};
      else if (sclk_fall && (stat_mode_r || rx_read_mode_r)) begin
        sdo_out <= tx_shift_r[15];
        tx_shift_r <= {tx_shift_r[14:0], 1'b0};
      end else if (sclk_fall)
        sdo_out <= 1'b0;
    end
  end

endmodule

// [spi_command_register_decoder_monitor.sv]
// concurrent checks on the command port boundary
`timescale 1ns/100ps
`include "spi_cmd_regs.svh"
module spi_command_register_decoder_monitor (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // observed pins
  input wire logic cs_n_in,
  input wire logic sdo_out,
  input wire logic sdo_oe_out,
  input wire logic rx_byte_read_out,
  input wire spi_cmd_pkg::cfg_regs_s cfg_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_idle;
    cs_n_in [*5];
  endsequence
  sequence s_sel;
    !cs_n_in [*5];
  endsequence

  property p_sdo_idle;
    s_idle |-> !sdo_out && !sdo_oe_out;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("serial output not low while deselected");
  property p_oe_sel;
    s_sel |-> sdo_oe_out;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("serial output not enabled while selected");
  property p_defaults;
    $rose(rst_n_in) |-> cfg_out.general_config == `RST_GENERAL_CONFIG
      && cfg_out.freq_ctrl_config == `RST_FREQ_CTRL_CONFIG && cfg_out.pll_config == `RST_PLL_CONFIG;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults missing after reset");
  property p_pll_one;
    cfg_out.pll_config[`PLL_FIXED_ONE_BIT];
  endproperty
  a_pll_one: assert property (p_pll_one) else $error("pll fixed bit not one");
  property p_unused_zero;
    !cfg_out.transmit_config[3] && !cfg_out.battery_and_clock_out[4];
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");
  property p_codes;
    cfg_out.general_config[15:8] == `CMD_GENERAL_CONFIG && cfg_out.freq_ctrl_config[15:8] == `CMD_FREQ_CTRL_CONFIG
      && cfg_out.transmit_config[15:9] == `CMD_TRANSMIT_CONFIG && cfg_out.wakeup_period[15:13] == `CMD_WAKEUP_PERIOD;
  endproperty
  a_codes: assert property (p_codes) else $error("register lost its command code");
  property p_hold;
    cs_n_in [*8] |=> $stable(cfg_out);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed while idle");
  property p_rx_pulse;
    rx_byte_read_out |=> !rx_byte_read_out;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("read pulse longer than one cycle");
  property p_rx_in_frame;
    rx_byte_read_out |-> !cs_n_in;
  endproperty
  a_rx_in_frame: assert property (p_rx_in_frame) else $error("read pulse outside a selection");
endmodule

bind spi_command_register_decoder spi_command_register_decoder_monitor u_mon (.sys_clk_in, .rst_n_in, .cs_n_in,
  .sdo_out, .sdo_oe_out, .rx_byte_read_out, .cfg_out);

// [spi_command_register_decoder_tb.sv]
// self-checking bench for the serial command port
`timescale 1ns/100ps
`include "spi_cmd_regs.svh"
module spi_command_register_decoder_tb;
  logic sys_clk_in;
  logic rst_n_in;
  logic sclk_in;
  logic cs_n_in;
  logic sdi_in;
  logic sdo_out;
  logic sdo_oe_out;
  logic sdo_pin;
  logic rx_byte_read_out;
  logic [15:0] status_src_in;
  logic [7:0] rx_byte_in;
  logic sleep_in;
  spi_cmd_pkg::cfg_regs_s cfg_out;
  logic [255:0] exp_cfg;
  logic [15:0] rd;
  int errors = 0;
  int checks = 0;
  int pulses = 0;
  localparam logic [255:0] dflt = {`RST_GENERAL_CONFIG, `RST_FREQ_CTRL_CONFIG, `RST_TRANSMIT_CONFIG,
    `RST_TRANSMIT_BYTE, `RST_CENTER_FREQUENCY, `RST_RECEIVE_CONTROL, `RST_BASEBAND_FILTER_CONFIG,
    `RST_RECEIVE_BYTE_READ, `RST_BUFFER_RESET_CONFIG, `RST_SYNC_PATTERN, `RST_DATA_RATE, `RST_POWER_MANAGEMENT,
    `RST_WAKEUP_PERIOD, `RST_DUTY_CYCLE, `RST_BATTERY_AND_CLOCK_OUT, `RST_PLL_CONFIG};
  // write word, target index (-1 none), value expected to be kept
  logic [15:0] wr [16] = '{16'h80a5, 16'hc43a, 16'h995f, 16'hb812, 16'ha123, 16'h95ab, 16'hc2d5, 16'hca5b,
    16'hce3c, 16'hc6fe, 16'h82f1, 16'hfabc, 16'hc855, 16'hc0ff, 16'hcc00, 16'h8155};
  int idx [16] = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 10, 11, 12, 13, 14, 15, -1};
  logic [15:0] kept [16] = '{16'h80a5, 16'hc43a, 16'h9957, 16'hb812, 16'ha123, 16'h95ab, 16'hc2d5, 16'hca5b,
    16'hce3c, 16'hc6fe, 16'h82f1, 16'hfabc, 16'hc855, 16'hc0ef, 16'hcc10, 16'h0000};

  // pin weakly held low when not driven
  assign sdo_pin = sdo_oe_out ? sdo_out : 1'b0;

  spi_command_register_decoder uut (.sys_clk_in, .rst_n_in, .sclk_in, .cs_n_in, .sdi_in, .sdo_out, .sdo_oe_out,
    .status_src_in, .rx_byte_in, .sleep_in, .cfg_out, .rx_byte_read_out);
  spi_cmd_host_model host (.sclk_out(sclk_in), .cs_n_out(cs_n_in), .sdi_out(sdi_in), .sdo_in(sdo_pin));

  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) begin
    if (rx_byte_read_out === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input string what, input logic [255:0] e, input logic [255:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task report_and_stop;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task do_reset;
    @(negedge sys_clk_in);
    rst_n_in = 1'b0;
    repeat (12) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    exp_cfg = dflt;
    chk("defaults", dflt, cfg_out);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_writes;
    for (int k = 0; k < 16; k++) begin
      host.xfer(wr[k], 16, rd);
      if (idx[k] >= 0) begin
        exp_cfg[255 - 16 * idx[k] -: 16] = kept[k];
      end
      chk("cfg after write", exp_cfg, cfg_out);
    end
    host.xfer(16'h80ff, 10, rd);
    chk("cfg after short word", exp_cfg, cfg_out);
    host.xfer(16'h80c3, 16, rd);
    exp_cfg[255 -: 16] = 16'h80c3;
    chk("cfg after fresh word", exp_cfg, cfg_out);
  endtask

  task t_status;
    @(negedge sys_clk_in);
    status_src_in = 16'h0c35;
    @(negedge sys_clk_in);
    status_src_in = 16'h0435;
    host.xfer(16'h0000, 16, rd);
    chk("status first read", 16'h4c35, rd);
    host.xfer(16'h0000, 16, rd);
    chk("status second read", 16'h0435, rd);
    chk("cfg after status", exp_cfg, cfg_out);
  endtask

  task t_rx_sleep;
    @(negedge sys_clk_in);
    rx_byte_in = 8'h6d;
    host.xfer(16'hb000, 16, rd);
    chk("rx byte on serial out", 16'h00da, rd);
    chk("read pulses", 1, pulses);
    chk("cfg after read", exp_cfg, cfg_out);
    sleep_in = 1'b1;
    repeat (40) @(negedge sys_clk_in);
    chk("cfg in sleep", exp_cfg, cfg_out);
    sleep_in = 1'b0;
  endtask

  initial begin
    rst_n_in = 1'b0;
    status_src_in = 16'h0000;
    rx_byte_in = 8'h00;
    sleep_in = 1'b0;
    do_reset;
    t_status;
    t_writes;
    t_rx_sleep;
    do_reset;
    report_and_stop;
  end

  initial begin
    #1000000;
    errors++;
    report_and_stop;
  end
endmodule
